// >>> rtl/urb_consts.svh
// constants for the uart receiver and break logic
`ifndef URB_CONSTS_SVH
`define URB_CONSTS_SVH

// bit timing
`define URB_CLK_HZ 10000000
`define URB_BAUD_HZ 156250
`define URB_OS_N 16
`define URB_OS_DIV (`URB_CLK_HZ / (`URB_BAUD_HZ * `URB_OS_N))
`define URB_SAMP_A 4'h7
`define URB_SAMP_B 4'h8
`define URB_SAMP_C 4'h9
`define URB_OS_LAST 4'hf
`define URB_BRK_ZEROS 5'hd
`define URB_REM_BRK_BITS 5'h10

// register byte offsets
`define URB_OFS_CTRL 4'h0
`define URB_OFS_STATUS 4'h4
`define URB_OFS_DATA 4'h8

// control register fields
`define URB_CTRL_RECEIVER_ENABLE_BIT 0
`define URB_CTRL_NINE 1
`define URB_CTRL_BRK 2
`define URB_CTRL_RIE 3
`define URB_CTRL_TWOSTOP 4
`define URB_CTRL_W 5
`define URB_CTRL_RST 5'h00

// status register fields
`define URB_ST_AVAIL 0
`define URB_ST_OVR 1
`define URB_ST_FRAMING_ERR_FLAG 2
`define URB_ST_NOISE 3
`define URB_ST_IDLE 4
`define URB_ST_TXBUSY 5
`define URB_ST_NINTH 8

`endif

// >>> rtl/urb_pkg.sv
// types shared by both ends of the uart receiver and break link
package urb_pkg;

  typedef enum logic [1:0] {URB_R_HUNT, URB_R_START, URB_R_DATA, URB_R_STOP} urb_rx_state_t;
  typedef enum logic [1:0] {URB_T_IDLE, URB_T_START, URB_T_ZERO, URB_T_STOP} urb_tx_state_t;

  // fifo entry: {noise, framing error, 9-bit word}
  typedef logic [10:0] urb_entry_t;

  typedef struct packed {
    logic [3:0] div;
    logic [4:0] ctrl;
    logic ack;
    logic [31:0] rdata;
    logic stat_seen;
    urb_rx_state_t rst;
    logic [3:0] ros;
    logic [3:0] rbits;
    logic [8:0] shreg;
    logic s1;
    logic s2;
    logic noise;
    logic armed;
    logic idle;
    logic [1:0][10:0] fifo;
    logic [1:0] cnt;
    logic rp;
    logic ovr;
    logic irq;
    urb_tx_state_t tst;
    logic [3:0] tos;
    logic [4:0] tcnt;
    logic tline;
  } urb_dev_state_t;

  typedef struct packed {
    logic [3:0] div;
    logic [3:0] tos;
    logic [4:0] tbits;
    logic [15:0] tsh;
    logic tbusy;
    logic tline;
    logic [11:0] lowcnt;
    logic brk;
    logic [7:0] brk_bits;
  } urb_rem_state_t;

endpackage

// >>> rtl/urb_if.sv
// serial link between the uart device and the remote party
`timescale 1ns/1ns
interface urb_if;
  logic line_to_dev;
  logic line_to_rem;

  modport dev (input line_to_dev, output line_to_rem);
  modport rem (output line_to_dev, input line_to_rem);
endinterface

// >>> rtl/urb_device.sv
// uart device: receiver with two-entry fifo, break transmitter, avalon-mm registers
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "urb_consts.svh"
module urb_device
  import urb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  urb_if.dev link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic rx_irq
);

  urb_dev_state_t s;
  urb_dev_state_t next_s;

  logic tick;
  logic req;
  logic acc;
  logic stat_rd;
  logic data_rd;
  logic ctrl_wr;
  logic pop;
  logic push;
  logic ovr_set;
  logic maj;
  logic framing_err_flag;
  logic line;
  logic wp;
  urb_entry_t head;
  urb_entry_t word;
  logic [31:0] status_word;

  assign req = avs_read | avs_write;
  // one wait state keeps read data a registered value
  assign avs_waitrequest = req & ~s.ack;
  assign avs_readdata = s.rdata;
  assign rx_irq = s.irq;
  assign link.line_to_rem = s.tline;
  assign line = link.line_to_dev;

  always_comb begin
    next_s = s;
    tick = (s.div == 4'(`URB_OS_DIV - 1));
    acc = req & s.ack;
    stat_rd = acc & avs_read & (avs_address == `URB_OFS_STATUS);
    data_rd = acc & avs_read & (avs_address == `URB_OFS_DATA);
    ctrl_wr = acc & avs_write & (avs_address == `URB_OFS_CTRL);
    head = s.fifo[s.rp];
    pop = data_rd & s.stat_seen & (s.cnt != 2'h0);
    push = 1'b0;
    ovr_set = 1'b0;
    maj = (s.s1 & s.s2) | (s.s1 & line) | (s.s2 & line);
    framing_err_flag = 1'b0;
    word = '0;
    wp = s.rp ^ s.cnt[0];

    status_word = '0;
    status_word[`URB_ST_AVAIL] = (s.cnt != 2'h0);
    status_word[`URB_ST_OVR] = s.ovr;
    status_word[`URB_ST_FRAMING_ERR_FLAG] = head[9];
    status_word[`URB_ST_NOISE] = head[10];
    status_word[`URB_ST_IDLE] = s.idle;
    status_word[`URB_ST_TXBUSY] = (s.tst != URB_T_IDLE);
    status_word[`URB_ST_NINTH] = head[8];

    next_s.div = tick ? 4'h0 : s.div + 4'h1;

    // avalon slave: ack one cycle after the request is seen
    next_s.ack = req & ~s.ack;
    if (req & ~s.ack) begin
      next_s.rdata = '0;
      if (avs_read) begin
        case (avs_address)
          `URB_OFS_CTRL: next_s.rdata = {27'h0, s.ctrl};
          `URB_OFS_STATUS: next_s.rdata = status_word;
          `URB_OFS_DATA: next_s.rdata = {23'h0, head[8:0]};
          default: next_s.rdata = '0;
        endcase
      end
    end
    if (ctrl_wr) begin
      next_s.ctrl = avs_writedata[`URB_CTRL_W-1:0];
    end
    // a status read arms the clearing data read
    next_s.stat_seen = stat_rd | (s.stat_seen & ~data_rd);

    // receiver, runs on the 16x oversample tick
    next_s.irq = 1'b0;
    if (tick) begin
      if (s.rst != URB_R_HUNT) begin
        next_s.ros = s.ros + 4'h1;
        if (s.ros == `URB_SAMP_A) begin
          next_s.s1 = line;
        end
        if (s.ros == `URB_SAMP_B) begin
          next_s.s2 = line;
        end
        if (s.ros == `URB_SAMP_C) begin
          // any disagreement among the three centre samples is noise
          if (!(s.s1 == s.s2 && s.s2 == line)) begin
            next_s.noise = 1'b1;
          end
        end
      end
      case (s.rst)
        URB_R_HUNT: begin
          next_s.idle = 1'b1;
          if (line) begin
            next_s.armed = 1'b1;
          end
          if (s.ctrl[`URB_CTRL_RECEIVER_ENABLE_BIT] && s.armed && !line) begin
            next_s.rst = URB_R_START;
            next_s.ros = 4'h0;
            next_s.rbits = 4'h0;
            next_s.noise = 1'b0;
            next_s.idle = 1'b0;
          end
        end
        URB_R_START: begin
          if (s.ros == `URB_SAMP_C && maj) begin
            next_s.rst = URB_R_HUNT;
            next_s.idle = 1'b1;
          end else if (s.ros == `URB_OS_LAST) begin
            next_s.rst = URB_R_DATA;
          end
        end
        URB_R_DATA: begin
          if (s.ros == `URB_SAMP_C) begin
            next_s.shreg = {maj, s.shreg[8:1]};
          end
          if (s.ros == `URB_OS_LAST) begin
            next_s.rbits = s.rbits + 4'h1;
            if (s.rbits == (s.ctrl[`URB_CTRL_NINE] ? 4'h8 : 4'h7)) begin
              next_s.rst = URB_R_STOP;
            end
          end
        end
        URB_R_STOP: begin
          if (s.ros == `URB_SAMP_C) begin
            framing_err_flag = ~maj;
            word[8:0] = s.ctrl[`URB_CTRL_NINE] ? s.shreg : {1'b0, s.shreg[8:1]};
            word[9] = framing_err_flag;
            word[10] = s.noise | (!(s.s1 == s.s2 && s.s2 == line));
            next_s.rst = URB_R_HUNT;
            next_s.idle = 1'b1;
            if (framing_err_flag) begin
              next_s.armed = 1'b0;
            end
            if ((s.cnt != 2'h2) || pop) begin
              push = 1'b1;
            end else begin
              ovr_set = 1'b1;
            end
            // noise alone never requests; it rides the transfer request
            next_s.irq = s.ctrl[`URB_CTRL_RIE];
          end
        end
        default: next_s.rst = URB_R_HUNT;
      endcase
      if (!s.ctrl[`URB_CTRL_RECEIVER_ENABLE_BIT]) begin
        next_s.rst = URB_R_HUNT;
        next_s.armed = 1'b0;
        next_s.idle = 1'b1;
      end
    end

    // fifo; on overrun the buffered words stay untouched
    if (push) begin
      next_s.fifo[wp] = word;
    end
    if (pop) begin
      next_s.rp = ~s.rp;
    end
    next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
    // set wins over a clear in the same cycle
    next_s.ovr = ovr_set | (s.ovr & ~(data_rd & s.stat_seen));

    // break transmitter; it has no transmit-empty request at all
    if (tick) begin
      if (s.tst != URB_T_IDLE) begin
        next_s.tos = s.tos + 4'h1;
      end
      case (s.tst)
        URB_T_IDLE: begin
          next_s.tline = 1'b1;
          if (s.ctrl[`URB_CTRL_BRK]) begin
            next_s.tst = URB_T_START;
            next_s.tos = 4'h0;
            next_s.tline = 1'b0;
          end
        end
        URB_T_START: begin
          if (s.tos == `URB_OS_LAST) begin
            next_s.tst = URB_T_ZERO;
            next_s.tcnt = 5'h0;
          end
        end
        URB_T_ZERO: begin
          if (s.tos == `URB_OS_LAST) begin
            next_s.tcnt = s.tcnt + 5'h1;
            if (s.tcnt == `URB_BRK_ZEROS - 5'h1) begin
              next_s.tcnt = 5'h0;
              if (!s.ctrl[`URB_CTRL_BRK]) begin
                next_s.tst = URB_T_STOP;
                next_s.tline = 1'b1;
              end
            end
          end
        end
        URB_T_STOP: begin
          if (s.tos == `URB_OS_LAST) begin
            if (s.ctrl[`URB_CTRL_TWOSTOP] && s.tcnt == 5'h0) begin
              next_s.tcnt = 5'h1;
            end else begin
              next_s.tst = URB_T_IDLE;
            end
          end
        end
        default: next_s.tst = URB_T_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.ctrl <= `URB_CTRL_RST;
      s.idle <= 1'b1;
      s.tline <= 1'b1;
      s.rst <= URB_R_HUNT;
      s.tst <= URB_T_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule

// >>> rtl/urb_remote.sv
// remote uart party: sends words or long breaks, measures low runs on the device line
`timescale 1ns/1ns
`include "urb_consts.svh"
module urb_remote
  import urb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  urb_if.rem link,
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [8:0] send_word,
  input wire logic send_nine,
  input wire logic send_break,
  output logic break_seen,
  output logic [7:0] break_bits
);

  urb_rem_state_t s;
  urb_rem_state_t next_s;
  logic tick;

  // frames start only on an oversample tick, so every bit, the first too, lasts sixteen ticks
  assign send_ready = ~s.tbusy & tick;
  assign link.line_to_dev = s.tline;
  assign break_seen = s.brk;
  assign break_bits = s.brk_bits;

  always_comb begin
    next_s = s;
    tick = (s.div == 4'(`URB_OS_DIV - 1));
    next_s.div = tick ? 4'h0 : s.div + 4'h1;
    next_s.brk = 1'b0;

    // words go out lsb first with one stop bit; a break is a long low run
    if (send_valid && !s.tbusy && tick) begin
      next_s.tbusy = 1'b1;
      next_s.tos = 4'h0;
      next_s.tline = 1'b0;
      if (send_break) begin
        next_s.tsh = 16'h0000;
        next_s.tbits = `URB_REM_BRK_BITS;
      end else if (send_nine) begin
        next_s.tsh = {5'h1f, 1'b1, send_word, 1'b0};
        next_s.tbits = 5'hb;
      end else begin
        next_s.tsh = {6'h3f, 1'b1, send_word[7:0], 1'b0};
        next_s.tbits = 5'ha;
      end
    end else if (tick && s.tbusy) begin
      next_s.tos = s.tos + 4'h1;
      if (s.tos == `URB_OS_LAST) begin
        if (s.tbits == 5'h1) begin
          next_s.tbusy = 1'b0;
          next_s.tline = 1'b1;
        end else begin
          next_s.tsh = {1'b1, s.tsh[15:1]};
          next_s.tline = s.tsh[1];
          next_s.tbits = s.tbits - 5'h1;
        end
      end
    end

    // low-run meter on the device line, reported when the line rises
    if (tick) begin
      if (!link.line_to_rem) begin
        if (s.lowcnt != 12'hfff) begin
          next_s.lowcnt = s.lowcnt + 12'h1;
        end
      end else if (s.lowcnt != 12'h000) begin
        next_s.brk = 1'b1;
        next_s.brk_bits = s.lowcnt[11:4];
        next_s.lowcnt = 12'h000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.tline <= 1'b1;
      s.tsh <= 16'hffff;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule

// >>> bench/urb_chk.sv
// link assertions between the uart device and the remote party
`timescale 1ns/1ns
module urb_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic line_to_dev,
  input wire logic line_to_rem
);
  logic [11:0] rlow;
  logic [11:0] rhi;
  logic [11:0] dlow;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // high run starts at 0x0ff, past a stop time, so a break right after reset is not flagged
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rlow <= 12'h000;
      rhi <= 12'h0ff;
      dlow <= 12'h000;
    end else begin
      rlow <= line_to_rem ? 12'h000 : rlow + 12'h001;
      rhi <= !line_to_rem ? 12'h000 : ((rhi == 12'hfff) ? rhi : rhi + 12'h001);
      dlow <= line_to_dev ? 12'h000 : dlow + 12'h001;
    end
  end
  a_rst_idle: assert property ($rose(rstn) |-> line_to_rem && line_to_dev)
    else $error("link not idle high after reset");
  a_brk_min: assert property ($rose(line_to_rem) |-> rlow >= 12'h380)
    else $error("break shorter than fourteen bits");
  a_brk_len: assert property ($rose(line_to_rem) |-> (rlow - 12'h040) % 12'h340 == 12'h000)
    else $error("break not start plus multiple of thirteen zeros");
  a_brk_stop: assert property ($fell(line_to_rem) |-> rhi >= 12'h040)
    else $error("stop time after break too short");
  a_brk_hold: assert property ($fell(line_to_rem) |=> !line_to_rem [*8])
    else $error("break glitched high");
  a_rx_bits: assert property ($rose(line_to_dev) |-> dlow[5:0] == 6'h00)
    else $error("remote low run not whole bits");
  a_rx_start: assert property ($rose(line_to_dev) |-> dlow >= 12'h040)
    else $error("remote start shorter than a bit");
  a_rx_maxlow: assert property (dlow <= 12'h400)
    else $error("remote low run too long");
endmodule

// >>> bench/uart_receiver_break_logic_tb.sv
// self-checking bench: device and remote joined over the serial link
`timescale 1ns/1ns
module uart_receiver_break_logic_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_irq;
  logic send_valid = 1'b0;
  logic send_ready;
  logic [8:0] send_word = 9'h000;
  logic send_nine = 1'b0;
  logic send_break = 1'b0;
  logic break_seen;
  logic [7:0] break_bits;
  logic [31:0] rdq;
  logic dev_ce = 1'b1;
  logic rem_ce = 1'b1;
  int n_mismatch = 0;
  int check_count = 0;
  int irq_n = 0;
  int cyc = 0;
  urb_if link ();
  always #50 sys_clk = ~sys_clk;
  urb_device u_urb_device (.sys_clk(sys_clk), .rstn(rstn), .ce(dev_ce), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_irq(rx_irq));
  urb_remote u_urb_remote (.sys_clk(sys_clk), .rstn(rstn), .ce(rem_ce), .link(link),
    .send_valid(send_valid), .send_ready(send_ready), .send_word(send_word),
    .send_nine(send_nine), .send_break(send_break), .break_seen(break_seen),
    .break_bits(break_bits));
  urb_chk u_urb_chk (.sys_clk(sys_clk), .rstn(rstn), .line_to_dev(link.line_to_dev),
    .line_to_rem(link.line_to_rem));
  task automatic end_of_test;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // values read right after the edge are the ones sampled at it
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), rdq, e);
  endtask
  // one bit time of settling lets the device finish its stop decision
  task automatic send(input logic [8:0] w, input logic nine, input logic brk);
    @(posedge sys_clk);
    send_word <= w;
    send_nine <= nine;
    send_break <= brk;
    send_valid <= 1'b1;
    do @(posedge sys_clk); while (send_ready !== 1'b1);
    send_valid <= 1'b0;
    do @(posedge sys_clk); while (send_ready !== 1'b1);
    repeat (64) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_irq === 1'b1) begin
      irq_n++;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rchk(4'h0, 32'h0);
    rchk(4'h4, 32'h10);
    bus(1'b1, 4'hc, 32'hff);
    rchk(4'hc, 32'h0);
    send(9'h05a, 1'b0, 1'b0);
    rchk(4'h4, 32'h10);
    bus(1'b1, 4'h0, 32'h9);
    send(9'h0a5, 1'b0, 1'b0);
    chk("irq count", 32'(irq_n), 32'h1);
    rchk(4'h4, 32'h11);
    rchk(4'h8, 32'ha5);
    rchk(4'h4, 32'h10);
    bus(1'b1, 4'h0, 32'hb);
    send(9'h1c3, 1'b1, 1'b0);
    rchk(4'h4, 32'h111);
    rchk(4'h8, 32'h1c3);
    bus(1'b1, 4'h0, 32'h9);
    for (int i = 1; i < 4; i++) begin
      send(9'h011 * 9'(i), 1'b0, 1'b0);
    end
    rchk(4'h4, 32'h13);
    rchk(4'h8, 32'h11);
    rchk(4'h4, 32'h11);
    rchk(4'h8, 32'h22);
    rchk(4'h4, 32'h10);
    chk("irq count", 32'(irq_n), 32'h5);
    send(9'h000, 1'b0, 1'b1);
    rchk(4'h4, 32'h15);
    rchk(4'h8, 32'h0);
    send(9'h03c, 1'b0, 1'b0);
    rchk(4'h4, 32'h11);
    rchk(4'h8, 32'h3c);
    chk("irq count", 32'(irq_n), 32'h7);
    bus(1'b1, 4'h0, 32'h1);
    send(9'h077, 1'b0, 1'b0);
    rchk(4'h4, 32'h11);
    rchk(4'h8, 32'h77);
    chk("irq count", 32'(irq_n), 32'h7);
    bus(1'b1, 4'h0, 32'h9);
    // a 36-cycle stall of the remote inside a high bit puts later edges between centre samples
    @(posedge sys_clk);
    send_word <= 9'h00f;
    send_valid <= 1'b1;
    do @(posedge sys_clk); while (send_ready !== 1'b1);
    send_valid <= 1'b0;
    repeat (150) @(posedge sys_clk);
    rem_ce <= 1'b0;
    repeat (36) @(posedge sys_clk);
    rem_ce <= 1'b1;
    do @(posedge sys_clk); while (send_ready !== 1'b1);
    repeat (64) @(posedge sys_clk);
    rchk(4'h4, 32'h19);
    rchk(4'h8, 32'h0f);
    rchk(4'h4, 32'h10);
    chk("irq count", 32'(irq_n), 32'h8);
    // a frozen device holds its bus handshake until the enable returns
    fork
      rchk(4'h4, 32'h10);
      begin
        @(posedge sys_clk);
        dev_ce <= 1'b0;
        repeat (20) @(posedge sys_clk);
        dev_ce <= 1'b1;
      end
    join
    for (int n = 1; n < 3; n++) begin
      bus(1'b1, 4'h0, (n == 2) ? 32'h1c : 32'hc);
      repeat (400 + 832 * (n - 1)) @(posedge sys_clk);
      rchk(4'h4, 32'h30);
      bus(1'b1, 4'h0, (n == 2) ? 32'h18 : 32'h8);
      do @(posedge sys_clk); while (break_seen !== 1'b1);
      chk("break length", 32'(break_bits), 32'(1 + 13 * n));
    end
    // two stop bits keep the transmitter busy past a single stop time
    repeat (100) @(posedge sys_clk);
    rchk(4'h4, 32'h30);
    repeat (64) @(posedge sys_clk);
    rchk(4'h4, 32'h10);
    chk("irq count", 32'(irq_n), 32'h8);
    end_of_test();
  end
endmodule
